// ### logic/cal_datapath.sv
// Purpose: subtract, compare, logic and right-shift datapath of the core
// Assumes: decoder presents one operation per cycle with operands already read
// Notes: one-cycle latency; flags live here and are shown on the outputs
`timescale 1ns/1ps
module cal_datapath import cal_pkg::*; (
  input logic mclk, // core clock
  input logic rst_b, // asynchronous reset, active low
  input logic op_valid, // operation presented this cycle
  input cal_op_t op_code, // operation
  input cal_cond_t op_cond, // conditional variant
  input logic op_imm, // second operand is the literal
  input logic op_sp, // subtract24 targets the stack pointer
  input logic [6:0] op_lit7, // seven-bit literal field
  input logic [12:0] op_lit13, // extension prefix value
  input logic [23:0] dest_data, // destination register value
  input logic [23:0] src_data, // source register value
  input logic [23:0] sp_data, // stack pointer value
  output logic res_valid_reg, // one-cycle result strobe
  output logic [23:0] res_data_reg, // result value
  output logic res_wr_dest_reg, // write result to destination
  output logic res_wr_sp_reg, // write result to stack pointer
  output logic flag_c_reg, // carry / borrow flag
  output logic flag_v_reg, // overflow flag
  output logic flag_n_reg, // negative flag
  output logic flag_z_reg, // zero flag
  output logic ext_pending_reg // extension prefix held
);

  cal_pfx_t pfx_reg;
  logic [12:0] ext_val_reg;
  logic [23:0] lit_u;
  logic [23:0] lit_s;
  logic is_cmp;
  logic is_shift;
  logic signed_lit;
  logic cond_ok;
  logic exec;
  logic [23:0] sub_a;
  logic [23:0] sub_b;
  logic sub_cin;
  logic sub_wide;
  logic [27:0] sub_out;
  logic [15:0] log_b;
  logic [23:0] cnt_src;
  logic [4:0] shift_cnt;
  logic [15:0] shift_res;
  logic [23:0] data_next;
  logic wr_dest_next;
  logic wr_sp_next;
  logic [3:0] flags_next;

  // ----------------------------------------
  // literal and operand selection
  // ----------------------------------------
  always_comb begin
    lit_u = cal_zext_lit(op_lit7, ext_val_reg, pfx_reg == CAL_PFX_HELD);
    lit_s = cal_sext_lit(op_lit7, ext_val_reg, pfx_reg == CAL_PFX_HELD);
    is_cmp = (op_code == CAL_OP_CMP16) || (op_code == CAL_OP_CMP24) || (op_code == CAL_OP_CMC);
    is_shift = (op_code == CAL_OP_SRL) || (op_code == CAL_OP_SRA);
    signed_lit = (op_code == CAL_OP_CMP16) || (op_code == CAL_OP_CMC);
    sub_a = (op_sp && op_code == CAL_OP_SUB24) ? sp_data : dest_data;
    sub_b = op_imm ? (signed_lit ? lit_s : lit_u) : src_data;
    sub_cin = ((op_code == CAL_OP_SBC) || (op_code == CAL_OP_CMC)) ? flag_c_reg : 1'b0;
    sub_wide = (op_code == CAL_OP_SUB24) || (op_code == CAL_OP_CMP24);
    sub_out = cal_sub(sub_a, sub_b, sub_cin, sub_wide);
    log_b = op_imm ? lit_s[15:0] : src_data[15:0];
    cnt_src = op_imm ? lit_u : src_data;
    shift_cnt = (cnt_src > {19'h00000, CAL_SHIFT_MAX}) ? CAL_SHIFT_MAX : cnt_src[4:0];
  end

  // ----------------------------------------
  // conditional execution
  // ----------------------------------------
  // literal, stack-pointer and shift forms have no conditional variant, so the field is ignored there
  always_comb begin
    if (op_imm || op_sp || is_shift) begin
      cond_ok = 1'b1;
    end else begin
      case (op_cond)
        CAL_COND_ALWAYS: cond_ok = 1'b1;
        CAL_COND_IF_C: cond_ok = flag_c_reg;
        CAL_COND_IF_NC: cond_ok = ~flag_c_reg;
        default: cond_ok = 1'b0;
      endcase
    end
    exec = op_valid && cond_ok && (op_code != CAL_OP_EXT) && (op_code != CAL_OP_NOP);
  end

  cal_shifter u_shift (
    .data_in(dest_data[15:0]),
    .count(shift_cnt),
    .arith(op_code == CAL_OP_SRA),
    .data_out(shift_res)
  );

  // ----------------------------------------
  // result and flag selection
  // ----------------------------------------
  always_comb begin
    data_next = CAL_DATA_RST;
    wr_dest_next = 1'b0;
    wr_sp_next = 1'b0;
    flags_next = {flag_c_reg, flag_v_reg, flag_n_reg, flag_z_reg};
    case (op_code)
      CAL_OP_SUB16, CAL_OP_SUB24, CAL_OP_SBC: begin
        data_next = sub_out[23:0];
        flags_next = sub_out[27:24];
        wr_sp_next = op_sp && (op_code == CAL_OP_SUB24);
        wr_dest_next = ~wr_sp_next;
      end
      CAL_OP_CMP16, CAL_OP_CMP24, CAL_OP_CMC: begin
        flags_next = sub_out[27:24];
      end
      CAL_OP_AND, CAL_OP_OR, CAL_OP_XOR, CAL_OP_NOT: begin
        case (op_code)
          CAL_OP_AND: data_next = {8'h00, dest_data[15:0] & log_b};
          CAL_OP_OR: data_next = {8'h00, dest_data[15:0] | log_b};
          CAL_OP_XOR: data_next = {8'h00, dest_data[15:0] ^ log_b};
          default: data_next = {8'h00, ~log_b};
        endcase
        wr_dest_next = 1'b1;
        flags_next = {flag_c_reg, 1'b0, data_next[15], (data_next[15:0] == 16'h0000)};
      end
      CAL_OP_SRL, CAL_OP_SRA: begin
        data_next = {8'h00, shift_res};
        wr_dest_next = 1'b1;
        flags_next = {flag_c_reg, 1'b0, shift_res[15], (shift_res == 16'h0000)};
      end
      default: begin
        data_next = CAL_DATA_RST;
      end
    endcase
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // a skipped conditional still strobes res_valid so the decoder sees it retire
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid_reg <= 1'b0;
      res_data_reg <= CAL_DATA_RST;
      res_wr_dest_reg <= 1'b0;
      res_wr_sp_reg <= 1'b0;
    end else begin
      res_valid_reg <= op_valid && (op_code != CAL_OP_EXT);
      res_data_reg <= exec ? data_next : CAL_DATA_RST;
      res_wr_dest_reg <= exec && wr_dest_next;
      res_wr_sp_reg <= exec && wr_sp_next;
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flag_c_reg <= CAL_FLAG_RST;
      flag_v_reg <= CAL_FLAG_RST;
      flag_n_reg <= CAL_FLAG_RST;
      flag_z_reg <= CAL_FLAG_RST;
    end else if (exec) begin
      {flag_c_reg, flag_v_reg, flag_n_reg, flag_z_reg} <= flags_next;
    end
  end

  // ----------------------------------------
  // extension prefix
  // ----------------------------------------
  // the prefix applies to exactly one following operation, even one that is skipped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pfx_reg <= CAL_PFX_IDLE;
      ext_val_reg <= CAL_EXT_RST;
      ext_pending_reg <= 1'b0;
    end else if (op_valid) begin
      case (op_code)
        CAL_OP_EXT: begin
          pfx_reg <= CAL_PFX_HELD;
          ext_val_reg <= op_lit13;
          ext_pending_reg <= 1'b1;
        end
        default: begin
          pfx_reg <= CAL_PFX_IDLE;
          ext_pending_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [15:0] chk_sub16;
  logic [15:0] chk_sbc16;
  logic [23:0] chk_sp24;
  logic [15:0] chk_and16;
  logic chk_plain;

  always_comb begin
    chk_sub16 = dest_data[15:0] - src_data[15:0];
    chk_sbc16 = dest_data[15:0] - src_data[15:0] - {15'h0000, flag_c_reg};
    chk_sp24 = sp_data - src_data;
    chk_and16 = dest_data[15:0] & src_data[15:0];
    chk_plain = op_valid && !op_imm && !op_sp && (op_cond == CAL_COND_ALWAYS);
  end

  property p_sub16_reg;
    @(posedge mclk) disable iff (!rst_b)
    chk_plain && op_code == CAL_OP_SUB16 |=> res_wr_dest_reg && res_data_reg == {8'h00, $past(chk_sub16)};
  endproperty
  a_sub16_reg: assert property (p_sub16_reg) else $error("16-bit subtract result wrong");

  property p_sbc16;
    @(posedge mclk) disable iff (!rst_b)
    chk_plain && op_code == CAL_OP_SBC |=> res_data_reg[15:0] == $past(chk_sbc16) && res_data_reg[23:16] == 8'h00;
  endproperty
  a_sbc16: assert property (p_sbc16) else $error("subtract with borrow result wrong");

  property p_sub24_sp;
    @(posedge mclk) disable iff (!rst_b)
    op_valid && op_code == CAL_OP_SUB24 && op_sp && !op_imm
      |=> res_wr_sp_reg && !res_wr_dest_reg && res_data_reg == $past(chk_sp24);
  endproperty
  a_sub24_sp: assert property (p_sub24_sp) else $error("stack pointer subtract wrong");

  property p_cmp_no_write;
    @(posedge mclk) disable iff (!rst_b)
    op_valid && is_cmp |=> res_valid_reg && !res_wr_dest_reg && !res_wr_sp_reg;
  endproperty
  a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare wrote a register");

  property p_cond_skip;
    @(posedge mclk) disable iff (!rst_b)
    op_valid && !op_imm && !op_sp && !is_shift && op_code != CAL_OP_EXT
      && ((op_cond == CAL_COND_IF_C && !flag_c_reg) || (op_cond == CAL_COND_IF_NC && flag_c_reg))
      |=> !res_wr_dest_reg && $stable(flag_c_reg) && $stable(flag_z_reg);
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("conditional ran against the carry");

  property p_and_reg;
    @(posedge mclk) disable iff (!rst_b)
    chk_plain && op_code == CAL_OP_AND |=> res_data_reg == {8'h00, $past(chk_and16)};
  endproperty
  a_and_reg: assert property (p_and_reg) else $error("AND result wrong");

  property p_not_sext;
    @(posedge mclk) disable iff (!rst_b)
    op_valid && op_code == CAL_OP_NOT && op_imm && !ext_pending_reg && op_lit7[6]
      |=> res_data_reg[15:6] == 10'h000 && res_wr_dest_reg;
  endproperty
  a_not_sext: assert property (p_not_sext) else $error("negative literal not sign-extended");

  property p_ext_next;
    @(posedge mclk) disable iff (!rst_b)
    op_valid && op_code == CAL_OP_EXT ##1 op_valid && op_code == CAL_OP_SUB16 && op_imm && !op_sp
      |=> res_data_reg[15:0] == $past(dest_data[15:0]) - {$past(ext_val_reg[8:0]), $past(op_lit7)};
  endproperty
  a_ext_next: assert property (p_ext_next) else $error("prefix did not widen literal");

  property p_srl_big;
    @(posedge mclk) disable iff (!rst_b)
    op_valid && op_code == CAL_OP_SRL && !op_imm && src_data > 24'h00000F |=> res_data_reg == 24'h000000;
  endproperty
  a_srl_big: assert property (p_srl_big) else $error("logical shift did not zero fill");

  property p_pfx_clear;
    @(posedge mclk) disable iff (!rst_b)
    ext_pending_reg && op_valid && op_code != CAL_OP_EXT |=> !ext_pending_reg;
  endproperty
  a_pfx_clear: assert property (p_pfx_clear) else $error("prefix outlived its operation");

endmodule

// ### include/cal_pkg.sv
// Purpose: shared constants, types and helpers of the subtract/compare/logic/shift datapath
// Assumes: one core clock, decoder presents one operation per cycle
// Notes: Behaviour list below
// Behaviour
// - 16-bit subtract of unsigned seven-bit literal
// - 24-bit register subtract keeps full result
// - 24-bit subtract can target the stack pointer
// - 24-bit literal subtract from destination or pointer
// - /c runs if carry set, /nc if clear
// - subtract with borrow: source plus carry, 16-bit
// - subtract with borrow also takes unsigned literal
// - 16-bit compare evaluates destination minus source
// - 16-bit compare takes signed seven-bit literal
// - 24-bit compare with register or unsigned literal
// - compare with carry, register or signed literal
// - bitwise AND with register or signed literal
// - bitwise OR with register or signed literal
// - exclusive OR with register or signed literal
// - inversion writes one's complement of operand
// - logical right shift by register count, zero fill
// - logical right shift count may be literal
// - arithmetic right shift replicates the sign bit
// - extension prefix widens next instruction's literal
package cal_pkg;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int CAL_W16 = 16;
  localparam int CAL_W24 = 24;
  localparam int CAL_LIT7_W = 7;
  localparam int CAL_LIT13_W = 13;
  localparam logic [4:0] CAL_SHIFT_MAX = 5'h10;
  localparam logic CAL_FLAG_RST = 1'b0;
  localparam logic [23:0] CAL_DATA_RST = 24'h000000;
  localparam logic [12:0] CAL_EXT_RST = 13'h0000;

  // ----------------------------------------
  // operation, condition and prefix state
  // ----------------------------------------
  typedef enum logic [3:0] {
    CAL_OP_NOP = 4'h0,
    CAL_OP_SUB16 = 4'h1,
    CAL_OP_SUB24 = 4'h2,
    CAL_OP_SBC = 4'h3,
    CAL_OP_CMP16 = 4'h4,
    CAL_OP_CMP24 = 4'h5,
    CAL_OP_CMC = 4'h6,
    CAL_OP_AND = 4'h7,
    CAL_OP_OR = 4'h8,
    CAL_OP_XOR = 4'h9,
    CAL_OP_NOT = 4'hA,
    CAL_OP_SRL = 4'hB,
    CAL_OP_SRA = 4'hC,
    CAL_OP_EXT = 4'hD
  } cal_op_t;

  typedef enum logic [1:0] {
    CAL_COND_ALWAYS = 2'h0,
    CAL_COND_IF_C = 2'h1,
    CAL_COND_IF_NC = 2'h2
  } cal_cond_t;

  typedef enum logic [0:0] {
    CAL_PFX_IDLE = 1'h0,
    CAL_PFX_HELD = 1'h1
  } cal_pfx_t;

  // ----------------------------------------
  // literal extension and subtraction
  // ----------------------------------------
  function automatic logic [23:0] cal_zext_lit(input logic [6:0] l7, input logic [12:0] l13, input logic pend);
    return pend ? {4'h0, l13, l7} : {17'h00000, l7};
  endfunction

  function automatic logic [23:0] cal_sext_lit(input logic [6:0] l7, input logic [12:0] l13, input logic pend);
    return pend ? {{4{l13[12]}}, l13, l7} : {{17{l7[6]}}, l7};
  endfunction

  // returns {c, v, n, z, result}; c is the borrow out
  function automatic logic [27:0] cal_sub(input logic [23:0] a, input logic [23:0] b, input logic cin,
                                          input logic wide);
    logic [24:0] d;
    logic [23:0] r;
    logic c;
    logic v;
    d = {1'b0, a} - {1'b0, b} - {24'h000000, cin};
    if (wide) begin
      r = d[23:0];
      c = d[24];
      v = (a[23] ^ b[23]) & (a[23] ^ r[23]);
      return {c, v, r[23], (r == 24'h000000), r};
    end
    d = {9'h000, a[15:0]} - {9'h000, b[15:0]} - {24'h000000, cin};
    r = {8'h00, d[15:0]};
    c = d[16];
    v = (a[15] ^ b[15]) & (a[15] ^ r[15]);
    return {c, v, r[15], (r[15:0] == 16'h0000), r};
  endfunction

endpackage

// ### logic/cal_shifter.sv
// Purpose: 16-bit right shifter, logical or arithmetic
// Assumes: count already saturated to 0..16
// Notes: purely combinational
`timescale 1ns/1ps
module cal_shifter import cal_pkg::*; (
  input logic [15:0] data_in, // value to shift
  input logic [4:0] count, // positions, 0..16
  input logic arith, // 1 replicates the sign bit
  output logic [15:0] data_out // shifted value
);

  logic [31:0] wide;

  // ----------------------------------------
  // fill word above the data, then shift
  // ----------------------------------------
  always_comb begin
    wide = {{16{arith & data_in[15]}}, data_in};
    wide = wide >> count;
    data_out = wide[15:0];
  end

endmodule

// ### testbench/cal_regfile_model.sv
// Purpose: register file behind the datapath, destination and stack pointer only
// Assumes: write strobes pulse one cycle with the result
// Notes: bypasses a result that is being written, as the core's register file must
`timescale 1ns/1ps
module cal_regfile_model (
  input logic mclk, // core clock
  input logic rst_b, // asynchronous reset, active low
  input logic ld_en, // preload strobe from the bench
  input logic [23:0] ld_dest, // preload value, destination
  input logic [23:0] ld_sp, // preload value, stack pointer
  input logic [23:0] res_data, // result from the datapath
  input logic wr_dest, // write destination
  input logic wr_sp, // write stack pointer
  output logic [23:0] dest_data, // destination operand
  output logic [23:0] sp_data // stack pointer operand
);
  logic [23:0] dest_reg;
  logic [23:0] sp_reg;

  // without the bypass a back-to-back op would read a stale operand
  assign dest_data = wr_dest ? res_data : dest_reg;
  assign sp_data = wr_sp ? res_data : sp_reg;

  // a preload wins over a write-back landing on the same edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dest_reg <= 24'h000000;
      sp_reg <= 24'h000000;
    end else if (ld_en) begin
      dest_reg <= ld_dest;
      sp_reg <= ld_sp;
    end else begin
      if (wr_dest) dest_reg <= res_data;
      if (wr_sp) sp_reg <= res_data;
    end
  end
endmodule

// ### testbench/cal_datapath_tb.sv
// Purpose: self-checking bench of the datapath against an integer model
// Assumes: one op per cycle, inputs changed at the falling edge
// Notes: the model is checked at every result, flags and prefix every cycle
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module cal_datapath_tb import cal_pkg::*;;
  logic mclk, rst_b, op_valid, op_imm, op_sp, ld_en;
  cal_op_t op_code;
  cal_cond_t op_cond;
  logic [6:0] op_lit7;
  logic [12:0] op_lit13;
  logic [23:0] src_data, dest_data, sp_data, ld_dest, ld_sp, res_data_reg;
  logic res_valid_reg, res_wr_dest_reg, res_wr_sp_reg, flag_c_reg, flag_v_reg, flag_n_reg, flag_z_reg;
  logic ext_pending_reg;
  int n_mismatch = 0;
  int checks_done = 0;
  bit [31:0] seed = 32'hEB782C87;
  bit [31:0] q;
  bit [23:0] m_dest, m_sp, e_data;
  bit [12:0] m_l13;
  bit mc, mv, mn, mz, m_pend, e_valid, e_wd, e_ws;

  cal_datapath i_dut (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .op_cond(op_cond),
    .op_imm(op_imm), .op_sp(op_sp), .op_lit7(op_lit7), .op_lit13(op_lit13), .dest_data(dest_data),
    .src_data(src_data), .sp_data(sp_data), .res_valid_reg(res_valid_reg), .res_data_reg(res_data_reg),
    .res_wr_dest_reg(res_wr_dest_reg), .res_wr_sp_reg(res_wr_sp_reg), .flag_c_reg(flag_c_reg),
    .flag_v_reg(flag_v_reg), .flag_n_reg(flag_n_reg), .flag_z_reg(flag_z_reg), .ext_pending_reg(ext_pending_reg));
  cal_regfile_model i_regs (.mclk(mclk), .rst_b(rst_b), .ld_en(ld_en), .ld_dest(ld_dest), .ld_sp(ld_sp),
    .res_data(res_data_reg), .wr_dest(res_wr_dest_reg), .wr_sp(res_wr_sp_reg), .dest_data(dest_data),
    .sp_data(sp_data));

  always #10 mclk = ~mclk;

  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ----------------------------------------
  // check last result, then drive and model the next op
  // ----------------------------------------
  task automatic step(input bit v, input bit [3:0] opc, input bit [1:0] cnd, input bit im, input bit ld);
    bit [23:0] zx, sx, b, a, r, ar;
    bit run, wd, ws, cin, nc, nv, nn, nz;
    int w, d, cnt;
    @(negedge mclk);
    `CHK("res_valid", e_valid, res_valid_reg)
    `CHK("wr_dest", e_wd, res_wr_dest_reg)
    `CHK("wr_sp", e_ws, res_wr_sp_reg)
    if (e_valid) `CHK("res_data", e_data, res_data_reg)
    `CHK("flags", {mc, mv, mn, mz}, {flag_c_reg, flag_v_reg, flag_n_reg, flag_z_reg})
    `CHK("ext_pending", m_pend, ext_pending_reg)
    `CHK("dest_operand", m_dest, dest_data)
    `CHK("sp_operand", m_sp, sp_data)
    q = xs();
    op_valid = v;
    op_code = cal_op_t'(opc);
    op_cond = cal_cond_t'(cnd);
    op_imm = im;
    op_sp = (opc == 4'h2) & q[20];
    op_lit7 = q[6:0];
    op_lit13 = q[19:7];
    q = xs();
    // short counts half the time so shifts hit the 15/16 boundary
    src_data = q[31] ? q[23:0] : {19'h00000, q[4:0]};
    ld_en = ld;
    ld_dest = xs();
    ld_sp = xs();
    zx = m_pend ? {4'h0, m_l13, op_lit7} : {17'h00000, op_lit7};
    sx = m_pend ? {{4{m_l13[12]}}, m_l13, op_lit7} : {{17{op_lit7[6]}}, op_lit7};
    b = !im ? src_data : (opc inside {4'h1, 4'h2, 4'h3, 4'h5, 4'hB, 4'hC}) ? zx : sx;
    run = im | op_sp | (opc inside {4'hB, 4'hC}) | (cnd == 2'h0) | (cnd == 2'h1 & mc) | (cnd == 2'h2 & !mc);
    a = op_sp ? m_sp : m_dest;
    if (opc inside {[4'h1:4'h6]}) begin
      w = (opc inside {4'h2, 4'h5}) ? 24 : 16;
      cin = (opc inside {4'h3, 4'h6}) & mc;
      d = int'(a & ((1 << w) - 1)) - int'(b & ((1 << w) - 1)) - int'(cin);
      r = 24'(d & ((1 << w) - 1));
      ar = (a ^ b) & (a ^ r);
      {nc, nv, nn, nz} = {d[w], ar[w-1], r[w-1], r == 24'h000000};
      wd = (opc inside {4'h1, 4'h2, 4'h3}) & !op_sp;
      ws = (opc == 4'h2) & op_sp;
    end else begin
      cnt = (b > 24'h000010) ? 16 : int'(b);
      case (opc)
        4'h7: r = {8'h00, m_dest[15:0] & b[15:0]};
        4'h8: r = {8'h00, m_dest[15:0] | b[15:0]};
        4'h9: r = {8'h00, m_dest[15:0] ^ b[15:0]};
        4'hA: r = {8'h00, ~b[15:0]};
        4'hB: r = {8'h00, m_dest[15:0] >> cnt};
        default: r = {8'h00, 16'($signed(m_dest[15:0]) >>> cnt)};
      endcase
      {nc, nv, nn, nz} = {mc, 1'b0, r[15], r[15:0] == 16'h0000};
      wd = 1'b1;
      ws = 1'b0;
    end
    run = run & v & (opc inside {[4'h1:4'hC]});
    e_valid = v & (opc != 4'hD);
    e_wd = run & wd;
    e_ws = run & ws;
    e_data = (e_wd | e_ws) ? r : 24'h000000;
    if (run) {mc, mv, mn, mz} = {nc, nv, nn, nz};
    m_dest = e_wd ? r : ld ? ld_dest : m_dest;
    m_sp = e_ws ? r : ld ? ld_sp : m_sp;
    if (v) begin
      m_pend = (opc == 4'hD);
      if (opc == 4'hD) m_l13 = op_lit13;
    end
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {mclk, rst_b, op_valid, op_imm, op_sp, ld_en} = 6'h00;
    op_code = CAL_OP_NOP;
    op_cond = CAL_COND_ALWAYS;
    {op_lit7, op_lit13, src_data, ld_dest, ld_sp} = 92'h0;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    step(1'b0, 4'h0, 2'h0, 1'b0, 1'b1);
    // every op with every condition code and operand kind, back to back
    for (int o = 0; o < 14; o++)
      for (int c = 0; c < 4; c++)
        for (int i = 0; i < 2; i++)
          step(1'b1, o[3:0], c[1:0], i[0], 1'b0);
    $display("test table done");
    repeat (1500) begin
      q = xs();
      step(q[2:0] != 3'h0, 4'(q[6:3] % 4'hE), q[8:7], q[9], q[12:10] == 3'h0);
    end
    step(1'b0, 4'h0, 2'h0, 1'b0, 1'b0);
    $display("test random done");
    end_of_test();
  end

  // the run needs under 1800 cycles; a hang is cut well after that
  initial begin
    #(4000 * 20);
    n_mismatch++;
    $display("BAD watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
